// [design/cfs_pkg.sv]
// Constants and types for the CPU flag register and the bank map.
// Assumes one CPU clock with a synchronous, active-high reset.
//
// Behaviour
// - Clear-file on flags: upper zero, zero set
// - Carry and nibble carry act as borrows
// - Nibble carry is carry out of bit 3
// - Carry is carry out of bit 7
// - Borrow polarity inverted: one means no borrow
// - Subtract by adding two's complement operand
// - Offsets 0Ch to 1Fh are peripheral registers
// - Up to 80 RAM bytes follow peripherals
// - Top 16 bytes are shared common RAM
// - General RAM also reachable as linear space
// - Same partitioning in banks 0 to 31
// - Flag-affecting op suppresses write to flags
// - Time-out and power-down ignore software writes
// - 12-bit address: 5 bank, 7 offset
// - First 12 offsets are core registers everywhere
package cfs_pkg;

  // ----------------------------------------------------------------
  // Flag register layout
  // ----------------------------------------------------------------
  localparam int CFS_C_BIT = 0;
  localparam int CFS_DC_BIT = 1;
  localparam int CFS_Z_BIT = 2;
  localparam int CFS_PD_BIT = 3;
  localparam int CFS_TO_BIT = 4;
  localparam logic [2:0] CFS_ARITH_RST = 3'h0;
  localparam logic CFS_TO_RST = 1'h1;
  localparam logic CFS_PD_RST = 1'h1;

  // ----------------------------------------------------------------
  // Address split and bank partitioning
  // ----------------------------------------------------------------
  localparam int CFS_ADDR_W = 12;
  localparam int CFS_BANK_W = 5;
  localparam int CFS_OFS_W = 7;
  localparam logic [6:0] CFS_FLAGS_OFS = 7'h03;
  localparam logic [6:0] CFS_SFR_FIRST = 7'h0C;
  localparam logic [6:0] CFS_RAM_FIRST = 7'h20;
  localparam logic [6:0] CFS_COMMON_FIRST = 7'h70;
  localparam logic [11:0] CFS_RAM_BYTES = 12'h050;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CFS_RGN_CORE,
    CFS_RGN_PERIPH,
    CFS_RGN_RAM,
    CFS_RGN_COMMON
  } cfs_region_t;

  typedef enum logic [2:0] {
    CFS_OP_NONE,
    CFS_OP_ADD,
    CFS_OP_SUB,
    CFS_OP_AND,
    CFS_OP_IOR,
    CFS_OP_XOR,
    CFS_OP_CLR
  } cfs_op_t;

endpackage

// [design/cfs_map_if.sv]
// Carrier between the flag block and its bank address decoder.
// Assumes the decoder is purely combinational.
`timescale 1ns/1ps
interface cfs_map_if;
  logic [11:0] addr;
  logic [4:0] bank;
  logic [6:0] offset;
  cfs_pkg::cfs_region_t region;
  logic [6:0] local_idx;
  logic [11:0] linear;

  modport decoder (
    input addr,
    output bank,
    output offset,
    output region,
    output local_idx,
    output linear
  );
  modport user (
    output addr,
    input bank,
    input offset,
    input region,
    input local_idx,
    input linear
  );
endinterface

// [design/cfs_bank_map.sv]
// Bank address decoder: splits a data address into bank and offset.
// Assumes the user drives addr; results are combinational.
`timescale 1ns/1ps
module cfs_bank_map (
  // Decoder side of the carrier
  cfs_map_if.decoder map
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [11:0] bank_base;

  assign map.bank = map.addr[11:7];
  assign map.offset = map.addr[6:0];
  assign bank_base = 12'(map.bank) * cfs_pkg::CFS_RAM_BYTES;

  always_comb begin
    // Same split applies to every bank
    if (map.offset < cfs_pkg::CFS_SFR_FIRST) begin
      map.region = cfs_pkg::CFS_RGN_CORE;
      map.local_idx = map.offset;
      map.linear = 12'h000;
    end else if (map.offset < cfs_pkg::CFS_RAM_FIRST) begin
      map.region = cfs_pkg::CFS_RGN_PERIPH;
      map.local_idx = map.offset - cfs_pkg::CFS_SFR_FIRST;
      map.linear = 12'h000;
    end else if (map.offset < cfs_pkg::CFS_COMMON_FIRST) begin
      map.region = cfs_pkg::CFS_RGN_RAM;
      map.local_idx = map.offset - cfs_pkg::CFS_RAM_FIRST;
      map.linear = bank_base + 12'(map.local_idx);
    end else begin
      map.region = cfs_pkg::CFS_RGN_COMMON;
      map.local_idx = map.offset - cfs_pkg::CFS_COMMON_FIRST;
      map.linear = 12'h000;
    end
  end

endmodule // cfs_bank_map

// [design/cfs_status_flags.sv]
// CPU flag register with arithmetic flags, reset-cause flags and
// the registered bank map of the instruction's destination.
// Assumes the execution logic presents one instruction per EXEC.
`timescale 1ns/1ps
module cfs_status_flags #(
  parameter int BANKS = 32
) (
  // Clock, reset, enable
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  // Instruction from execution logic
  input wire logic EXEC,
  input wire logic [2:0] OP,
  input wire logic [7:0] OPA,
  input wire logic [7:0] OPB,
  input wire logic DEST_WR,
  input wire logic [11:0] DEST_ADDR,
  // Hardware flag events
  input wire logic WDT_CLEAR,
  input wire logic SLEEP_EXEC,
  input wire logic WDT_TIMEOUT,
  // Flag register and result
  output logic [7:0] STATUS,
  output logic [7:0] RESULT,
  output logic RESULT_VALID,
  // Destination map
  output logic [1:0] REGION,
  output logic [4:0] BANK,
  output logic [6:0] LOCAL_IDX,
  output logic [11:0] LINEAR
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (BANKS < 1 || BANKS > 32) begin : g_bad_banks
    $error("BANKS must be 1 to 32");
  end

  // ----------------------------------------------------------------
  // Bank decoder
  // ----------------------------------------------------------------
  cfs_map_if map_bus ();
  cfs_bank_map u_map (
    .map(map_bus.decoder)
  );
  assign map_bus.addr = DEST_ADDR;

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  cfs_pkg::cfs_op_t op;
  logic [7:0] opb_eff;
  logic cin;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] res;
  logic hits_flags;
  logic sets_carries;
  logic sets_zero;

  assign op = cfs_pkg::cfs_op_t'(OP);

  always_comb begin
    opb_eff = OPB;
    cin = 1'h0;
    if (op == cfs_pkg::CFS_OP_SUB) begin
      opb_eff = ~OPB;
      cin = 1'h1;
    end
    sum9 = {1'h0, OPA} + {1'h0, opb_eff} + {8'h00, cin};
    nib5 = {1'h0, OPA[3:0]} + {1'h0, opb_eff[3:0]} + {4'h0, cin};
    case (op)
      cfs_pkg::CFS_OP_ADD: res = sum9[7:0];
      cfs_pkg::CFS_OP_SUB: res = sum9[7:0];
      cfs_pkg::CFS_OP_AND: res = OPA & OPB;
      cfs_pkg::CFS_OP_IOR: res = OPA | OPB;
      cfs_pkg::CFS_OP_XOR: res = OPA ^ OPB;
      cfs_pkg::CFS_OP_CLR: res = 8'h00;
      default: res = OPA;
    endcase
  end

  assign sets_carries = (op == cfs_pkg::CFS_OP_ADD) ||
                        (op == cfs_pkg::CFS_OP_SUB);
  assign sets_zero = sets_carries || (op == cfs_pkg::CFS_OP_AND) ||
                     (op == cfs_pkg::CFS_OP_IOR) ||
                     (op == cfs_pkg::CFS_OP_XOR) ||
                     (op == cfs_pkg::CFS_OP_CLR);
  // Flag register seen at the same offset in every bank
  assign hits_flags = DEST_WR &&
                      (map_bus.offset == cfs_pkg::CFS_FLAGS_OFS);

  // ----------------------------------------------------------------
  // Arithmetic flags
  // ----------------------------------------------------------------
  logic z_r;
  logic dc_r;
  logic c_r;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      {z_r, dc_r, c_r} <= cfs_pkg::CFS_ARITH_RST;
    end else if (CE && EXEC) begin
      if (sets_zero) begin
        z_r <= (res == 8'h00);
      end else if (hits_flags) begin
        z_r <= res[cfs_pkg::CFS_Z_BIT];
      end
      if (sets_carries) begin
        c_r <= sum9[8];
        dc_r <= nib5[4];
      end else if (hits_flags && !sets_zero) begin
        c_r <= res[cfs_pkg::CFS_C_BIT];
        dc_r <= res[cfs_pkg::CFS_DC_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset-cause flags, hardware only
  // ----------------------------------------------------------------
  logic to_n_r;
  logic pd_n_r;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      to_n_r <= cfs_pkg::CFS_TO_RST;
      pd_n_r <= cfs_pkg::CFS_PD_RST;
    end else if (CE) begin
      if (WDT_TIMEOUT) begin
        to_n_r <= 1'h0;
      end else if (WDT_CLEAR || SLEEP_EXEC) begin
        to_n_r <= 1'h1;
      end
      if (SLEEP_EXEC) begin
        pd_n_r <= 1'h0;
      end else if (WDT_CLEAR) begin
        pd_n_r <= 1'h1;
      end
    end
  end

  // Unimplemented top bits are constant zero
  assign STATUS = {3'h0, to_n_r, pd_n_r, z_r, dc_r, c_r};

  // ----------------------------------------------------------------
  // Result and destination map
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      RESULT <= 8'h00;
      RESULT_VALID <= 1'h0;
    end else if (CE) begin
      RESULT_VALID <= EXEC;
      if (EXEC) begin
        RESULT <= res;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      REGION <= 2'h0;
      BANK <= 5'h00;
      LOCAL_IDX <= 7'h00;
      LINEAR <= 12'h000;
    end else if (CE && EXEC) begin
      REGION <= map_bus.region;
      BANK <= map_bus.bank;
      LOCAL_IDX <= map_bus.local_idx;
      LINEAR <= map_bus.linear;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  logic quiet;
  assign quiet = !WDT_TIMEOUT && !WDT_CLEAR && !SLEEP_EXEC;

  clear_flags_a: assert property (
    CE && EXEC && op == cfs_pkg::CFS_OP_CLR && hits_flags && quiet
    |=> STATUS[7:5] == 3'h0 && z_r && $stable(STATUS[4:3])
        && $stable(STATUS[1:0]))
    else $error("clear of flag register gave wrong pattern");

  add_carry_a: assert property (
    CE && EXEC && op == cfs_pkg::CFS_OP_ADD
    |=> c_r == ((9'($past(OPA)) + 9'($past(OPB))) > 9'h0FF))
    else $error("add carry wrong");

  sub_borrow_a: assert property (
    CE && EXEC && op == cfs_pkg::CFS_OP_SUB
    |=> c_r == ($past(OPA) >= $past(OPB))
        && dc_r == ($past(OPA[3:0]) >= $past(OPB[3:0])))
    else $error("subtract borrow polarity wrong");

  nibble_carry_a: assert property (
    CE && EXEC && op == cfs_pkg::CFS_OP_ADD
    |=> dc_r == ((5'($past(OPA[3:0])) + 5'($past(OPB[3:0]))) > 5'h0F))
    else $error("nibble carry wrong");

  zero_flag_a: assert property (
    CE && EXEC && sets_zero |=> RESULT_VALID && z_r == (RESULT == 8'h00))
    else $error("zero flag disagrees with result");

  timeout_flag_a: assert property (
    CE && WDT_TIMEOUT |=> !to_n_r)
    else $error("time-out flag not cleared by time-out");

  timeout_hold_a: assert property (
    !to_n_r && (!CE || quiet) |=> !to_n_r)
    else $error("time-out flag not held low");

  sleep_flag_a: assert property (
    CE && SLEEP_EXEC && !WDT_TIMEOUT |=> !pd_n_r && to_n_r)
    else $error("sleep did not mark power-down");

  write_guard_a: assert property (
    CE && EXEC && hits_flags && op == cfs_pkg::CFS_OP_AND
    |=> $stable(c_r) && $stable(dc_r))
    else $error("flag-affecting op wrote carry bits");

  hw_only_a: assert property (
    CE && EXEC && hits_flags && quiet |=> $stable(STATUS[4:3]))
    else $error("software changed reset-cause flags");

  core_region_a: assert property (
    CE && EXEC && DEST_ADDR[6:0] < 7'h0C
    |=> REGION == 2'(cfs_pkg::CFS_RGN_CORE) && BANK == $past(DEST_ADDR[11:7]))
    else $error("core offsets decoded wrongly");

  linear_ram_a: assert property (
    CE && EXEC && DEST_ADDR[6:0] >= 7'h20 && DEST_ADDR[6:0] < 7'h70
    |=> LINEAR == 12'($past(DEST_ADDR[11:7])) * 12'h050
                  + 12'($past(DEST_ADDR[6:0]) - 7'h20))
    else $error("linear address wrong");

  stall_a: assert property (!CE |=> $stable(STATUS) && $stable(RESULT))
    else $error("state moved with enable low");

  sub_cover: cover property (CE && EXEC && op == cfs_pkg::CFS_OP_SUB);
  clr_cover: cover property (CE && EXEC && op == cfs_pkg::CFS_OP_CLR
                             && hits_flags);
  common_cover: cover property (CE && EXEC && DEST_ADDR[6:0] >= 7'h70);
  sleep_cover: cover property (CE && SLEEP_EXEC);

endmodule // cfs_status_flags

// [tb/cfs_exec_model.sv]
// Execution-side model: drives instructions and flag events.
// Assumes one caller thread and MCLK from the bench.
`timescale 1ns/1ps
module cfs_exec_model (
  // Clock
  input wire logic MCLK,
  // Instruction
  output logic EXEC,
  output logic [2:0] OP,
  output logic [7:0] OPA,
  output logic [7:0] OPB,
  output logic DEST_WR,
  output logic [11:0] DEST_ADDR,
  // Flag events
  output logic WDT_CLEAR,
  output logic SLEEP_EXEC,
  output logic WDT_TIMEOUT
);
  initial begin
    {EXEC, OP, OPA, OPB, DEST_WR, DEST_ADDR} = '0;
    {WDT_CLEAR, SLEEP_EXEC, WDT_TIMEOUT} = 3'h0;
  end

  // One instruction, one cycle of EXEC
  task automatic issue(input logic [2:0] op, input logic [7:0] a, b,
                       input logic wr, input logic [11:0] ad);
    @(posedge MCLK);
    EXEC <= 1'b1;
    OP <= op;
    OPA <= a;
    OPB <= b;
    DEST_WR <= wr;
    DEST_ADDR <= ad;
    @(posedge MCLK);
    EXEC <= 1'b0;
    DEST_WR <= 1'b0;
    OPA <= ~a;
    OPB <= ~b;
  endtask

  // Event bits: timeout, sleep, clear
  task automatic pulse(input logic [2:0] e);
    @(posedge MCLK);
    {WDT_TIMEOUT, SLEEP_EXEC, WDT_CLEAR} <= e;
    @(posedge MCLK);
    {WDT_TIMEOUT, SLEEP_EXEC, WDT_CLEAR} <= 3'h0;
  endtask
endmodule // cfs_exec_model

// [tb/testbench.sv]
// Self-checking bench for the flag register and destination map.
// Assumes the execution model drives instruction and event inputs.
`timescale 1ns/1ps
module testbench;
  logic MCLK, RST, CE, EXEC, DEST_WR, RESULT_VALID;
  logic WDT_CLEAR, SLEEP_EXEC, WDT_TIMEOUT;
  logic [2:0] OP;
  logic [7:0] OPA, OPB, STATUS, RESULT, exp_st;
  logic [11:0] DEST_ADDR, LINEAR;
  logic [1:0] REGION;
  logic [4:0] BANK;
  logic [6:0] LOCAL_IDX;
  int miscompares = 0;
  int check_count = 0;
  // {op, a, b, addr}
  logic [31:0] tbl [11] = '{32'h1FF01000, 32'h10F0108B, 32'h1808010C,
    32'h2050319F, 32'h20305220, 32'h210012EF, 32'h3F00F370,
    32'h4000047F, 32'h55A5AF83, 32'h17F01FF0, 32'h200000A5};

  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  cfs_status_flags DUT (.MCLK(MCLK), .RST(RST), .CE(CE), .EXEC(EXEC),
    .OP(OP), .OPA(OPA), .OPB(OPB), .DEST_WR(DEST_WR),
    .DEST_ADDR(DEST_ADDR), .WDT_CLEAR(WDT_CLEAR),
    .SLEEP_EXEC(SLEEP_EXEC), .WDT_TIMEOUT(WDT_TIMEOUT),
    .STATUS(STATUS), .RESULT(RESULT), .RESULT_VALID(RESULT_VALID),
    .REGION(REGION), .BANK(BANK), .LOCAL_IDX(LOCAL_IDX), .LINEAR(LINEAR));

  cfs_exec_model cpu (.MCLK(MCLK), .EXEC(EXEC), .OP(OP), .OPA(OPA),
    .OPB(OPB), .DEST_WR(DEST_WR), .DEST_ADDR(DEST_ADDR),
    .WDT_CLEAR(WDT_CLEAR), .SLEEP_EXEC(SLEEP_EXEC),
    .WDT_TIMEOUT(WDT_TIMEOUT));

  task automatic chk(input string nm, input logic [11:0] e, g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic run(input logic [2:0] op, input logic [7:0] a, b,
                     input logic wr, input logic [11:0] ad);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] r;
    logic [6:0] o, base;
    logic [1:0] rg;
    logic [11:0] lin;
    // Plain subtract; a borrow shows as a set top bit
    s = (op == 3'h2) ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    n = (op == 3'h2) ? {1'b0, a[3:0]} - {1'b0, b[3:0]}
                     : {1'b0, a[3:0]} + {1'b0, b[3:0]};
    case (op)
      3'h1, 3'h2: r = s[7:0];
      3'h3: r = a & b;
      3'h4: r = a | b;
      3'h5: r = a ^ b;
      3'h6: r = 8'h00;
      default: r = a;
    endcase
    if (op == 3'h1) exp_st[1:0] = {n[4], s[8]};
    if (op == 3'h2) exp_st[1:0] = ~{n[4], s[8]};
    if (op != 3'h0) exp_st[2] = (r == 8'h00);
    o = ad[6:0];
    if (wr && o == 7'h03 && op == 3'h0) exp_st[2:0] = r[2:0];
    rg = (o < 7'h0C) ? 2'h0 : (o < 7'h20) ? 2'h1 : (o < 7'h70) ? 2'h2 : 2'h3;
    base = (rg == 2'h0) ? 7'h00 : (rg == 2'h1) ? 7'h0C :
           (rg == 2'h2) ? 7'h20 : 7'h70;
    lin = (rg == 2'h2) ? 12'(ad[11:7]) * 12'h050 + 12'(o - 7'h20) : 12'h000;
    cpu.issue(op, a, b, wr, ad);
    #1;
    chk("result", 12'(r), 12'(RESULT));
    chk("status", 12'(exp_st), 12'(STATUS));
    chk("valid", 12'h001, 12'(RESULT_VALID));
    chk("region", 12'(rg), 12'(REGION));
    chk("bank", 12'(ad[11:7]), 12'(BANK));
    chk("index", 12'(o - base), 12'(LOCAL_IDX));
    chk("linear", lin, LINEAR);
  endtask

  // Event bits: timeout, sleep, clear
  task automatic ev(input logic [2:0] e);
    if (e[2]) exp_st[4] = 1'b0;
    else if (e[1] || e[0]) exp_st[4] = 1'b1;
    if (e[1]) exp_st[3] = 1'b0;
    else if (e[0]) exp_st[3] = 1'b1;
    cpu.pulse(e);
    #1;
    chk("status", 12'(exp_st), 12'(STATUS));
    chk("valid", 12'h000, 12'(RESULT_VALID));
  endtask

  task automatic complete_run;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #20000;
    miscompares++;
    complete_run();
  end

  initial begin
    RST = 1'b1;
    CE = 1'b1;
    exp_st = 8'h18;
    repeat (20) @(posedge MCLK);
    RST <= 1'b0;
    #1;
    chk("status", 12'(exp_st), 12'(STATUS));
    chk("result", 12'h000, 12'(RESULT));
    chk("valid", 12'h000, 12'(RESULT_VALID));
    foreach (tbl[i])
      run(tbl[i][30:28], tbl[i][27:20], tbl[i][19:12], 1'b0, tbl[i][11:0]);
    $display("test arithmetic and map done");
    @(posedge MCLK);
    CE <= 1'b0;
    cpu.issue(3'h1, 8'h01, 8'h01, 1'b1, 12'h003);
    #1;
    chk("frozen", 12'(exp_st), 12'(STATUS));
    chk("frozen result", 12'h000, 12'(RESULT));
    @(posedge MCLK);
    RST <= 1'b1;
    @(posedge MCLK);
    RST <= 1'b0;
    CE <= 1'b1;
    #1;
    exp_st = 8'h18;
    chk("status", 12'(exp_st), 12'(STATUS));
    chk("result", 12'h000, 12'(RESULT));
    chk("valid", 12'h000, 12'(RESULT_VALID));
    $display("test enable and reset done");
    ev(3'h4);
    ev(3'h2);
    ev(3'h1);
    ev(3'h6);
    $display("test flag events done");
    run(3'h0, 8'hFF, 8'h00, 1'b1, 12'h083);
    run(3'h3, 8'h0F, 8'hF0, 1'b1, 12'h103);
    run(3'h6, 8'h00, 8'h00, 1'b1, 12'hF83);
    run(3'h0, 8'h00, 8'h00, 1'b1, 12'h203);
    run(3'h1, 8'hF0, 8'h10, 1'b1, 12'h383);
    ev(3'h5);
    $display("test flag writes done");
    complete_run();
  end
endmodule // testbench
